// file: verilog/atacp_pkg.sv
// Shared constants, types and helpers for the ATA command protocol engine
`default_nettype none
package atacp_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SECTOR_WORDS = 256;
	localparam int UDMA_MODES = 6;
	// Least strobe period per Ultra DMA mode, ns
	localparam int UDMA_MIN_NS [UDMA_MODES] = '{120, 80, 60, 45, 30, 20};
	localparam logic [15:0] CRC_SEED = 16'h4ABA;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_ACTION = 8'h00;
	localparam logic [7:0] OFS_CONFIG = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_ERRADDR = 8'h0C;
	localparam logic [7:0] OFS_TXWORD = 8'h10;
	localparam logic [7:0] OFS_RXWORD = 8'h14;
	localparam logic [7:0] OFS_CRC = 8'h18;
	// ACTION bits, write-one pulses
	localparam int ACT_GRANT = 0;
	localparam int ACT_PROC = 1;
	localparam int ACT_DONE = 2;
	localparam int ACT_ABORT = 3;
	localparam int ACT_FAULT = 4;
	localparam int ACT_DMA = 5;
	localparam int ACT_CAUSE_LSB = 8;
	// CONFIG fields
	localparam int CFG_UDMA_EN = 0;
	localparam int CFG_MODE_LSB = 1;
	localparam int CFG_MULT_LSB = 8;
	localparam int CFG_CLASS_LSB = 16;
	localparam int CFG_DIR_IN = 18;
	localparam int CFG_MW_LSB = 20;
	// Power-up: Ultra DMA off, multiword DMA mode 2
	localparam logic [31:0] CFG_RESET = 32'h0020_0000;
	localparam int ERR_ABRT_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Host pin vector positions
	localparam int P_RST = 6;
	localparam int P_CMD = 5;
	localparam int P_DATA = 4;
	localparam int P_STAT = 3;
	localparam int P_DMACK = 2;
	localparam int P_STOP = 1;
	localparam int P_RDY = 0;
	localparam int PIN_W = 7;

	typedef enum logic [1:0] {CLS_NODATA = 2'b00, CLS_PIO = 2'b01, CLS_PIOMULT = 2'b10,
		CLS_DMA = 2'b11} atacp_class_t;
	typedef enum logic [2:0] {C_IDLE = 3'b000, C_BUSY = 3'b001, C_DRQ = 3'b010,
		C_PROC = 3'b011, C_DMA = 3'b100} atacp_cmd_t;
	typedef enum logic [2:0] {B_IDLE = 3'b000, B_REQ = 3'b001, B_XFER = 3'b010,
		B_TREQ = 3'b011, B_TACK = 3'b100} atacp_burst_t;

	function automatic int cyclesMin(input int ns);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction

	// Bit-serial form of x^16+x^12+x^5+1, data bit 0 first
	function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [15:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 16; i++)
		begin
			r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// file: verilog/atacp_engine.sv
// Device-side ATA command protocol engine with Ultra DMA bursts
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module atacp_engine #(
	parameter int UDMA_NS [atacp_pkg::UDMA_MODES] = atacp_pkg::UDMA_MIN_NS
) (
	input wire logic clk, // 250 MHz core clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic hReset, // Host hard or soft reset
	input wire logic hCmdWr, // Host command register write
	input wire logic hDataWr, // Host data register write
	input wire logic hStatRd, // Host status register read
	input wire logic [15:0] ddIn, // Data bus from host
	input wire logic dmackN, // DMA acknowledge, low active
	input wire logic hStop, // Host STOP
	input wire logic hRdyStb, // HDMARDY- or HSTROBE
	output logic [15:0] ddOut, // Data bus to host
	output logic ddOe, // Data bus drive enable
	output logic dmarq, // DMA request
	output logic dRdyStb, // DDMARDY- or DSTROBE
	output logic intrq, // Interrupt request
	output logic bsy, // Status busy
	output logic drq, // Status data request
	output logic err, // Status error
	output logic [7:0] errReg, // Error register
	output logic [7:0] opcode, // Latched command code
	output logic [27:0] errAddr, // Failing sector address
	output logic errAddrLoad // Pulse: load errAddr
);
	// ----------------------------------------------------------------
	// Mode periods and parameter check
	// ----------------------------------------------------------------
	logic [7:0] modeCyc [atacp_pkg::UDMA_MODES];
	for (genvar g = 0; g < atacp_pkg::UDMA_MODES; g++)
	begin : gMode
		if (atacp_pkg::cyclesMin(UDMA_NS[g]) > 255)
		begin : gBad
			$error("Ultra DMA period too long for the gap counter");
		end
		assign modeCyc[g] = 8'(atacp_pkg::cyclesMin(UDMA_NS[g]));
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [atacp_pkg::PIN_W-1:0] pinA, pinS, pinD;
	logic [15:0] ddA, ddS;
	always_ff @(posedge clk)
	begin
		pinA <= {hReset, hCmdWr, hDataWr, hStatRd, dmackN, hStop, hRdyStb};
		pinS <= pinA;
		pinD <= pinS;
		ddA <= ddIn;
		ddS <= ddA;
	end
	logic cmdEdge, dataEdge, statEdge, stbEdge, dmackOn, stopOn, rdyOn, hostRst;
	assign cmdEdge = pinS[atacp_pkg::P_CMD] & ~pinD[atacp_pkg::P_CMD];
	assign dataEdge = pinS[atacp_pkg::P_DATA] & ~pinD[atacp_pkg::P_DATA];
	assign statEdge = pinS[atacp_pkg::P_STAT] & ~pinD[atacp_pkg::P_STAT];
	assign stbEdge = pinS[atacp_pkg::P_RDY] ^ pinD[atacp_pkg::P_RDY];
	assign dmackOn = ~pinS[atacp_pkg::P_DMACK];
	assign stopOn = pinS[atacp_pkg::P_STOP];
	assign rdyOn = ~pinS[atacp_pkg::P_RDY];
	assign hostRst = pinS[atacp_pkg::P_RST];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	atacp_pkg::atacp_cmd_t cmdSt, next_cmdSt;
	atacp_pkg::atacp_burst_t bst, next_bst;
	logic [31:0] cfg, next_cfg, next_rdata;
	logic [15:0] wordCnt, next_wordCnt, crc, next_crc, hostCrc, next_hostCrc;
	logic [15:0] txWord, next_txWord, rxWord, next_rxWord, next_ddOut;
	logic [8:0] burstCnt, next_burstCnt;
	logic [7:0] gapCnt, next_gapCnt, next_errReg, next_opcode;
	logic [27:0] next_errAddr;
	logic [1:0] next_bresp, next_rresp;
	logic txValid, next_txValid, rxValid, next_rxValid, pend, next_pend;
	logic crcErr, next_crcErr, next_ddOe, next_dmarq, next_dRdyStb, next_intrq;
	logic next_bsy, next_drq, next_err, next_errAddrLoad;
	logic next_awready, next_bvalid, next_arready, next_rvalid;

	// Decoded fields and strobes
	logic [31:0] wMask, wd, act, rdWord;
	logic [7:0] wA, rA, mult, period;
	logic [2:0] modeRaw, modeSel;
	logic [15:0] blockWords;
	logic wrTake, rdTake, rdHit, udmaEn, dirIn, setIntr, finish, rxTake;
	atacp_pkg::atacp_class_t cls;

	assign udmaEn = cfg[atacp_pkg::CFG_UDMA_EN];
	assign modeRaw = cfg[atacp_pkg::CFG_MODE_LSB +: 3];
	assign modeSel = (modeRaw > 3'(atacp_pkg::UDMA_MODES - 1)) ?
		3'(atacp_pkg::UDMA_MODES - 1) : modeRaw;
	assign period = modeCyc[modeSel];
	assign mult = cfg[atacp_pkg::CFG_MULT_LSB +: 8];
	assign cls = atacp_pkg::atacp_class_t'(cfg[atacp_pkg::CFG_CLASS_LSB +: 2]);
	assign dirIn = cfg[atacp_pkg::CFG_DIR_IN];
	// Zero multiple count falls back to one sector
	assign blockWords = (cls == atacp_pkg::CLS_PIOMULT && mult != 8'h00) ?
		16'(mult * atacp_pkg::SECTOR_WORDS) : 16'(atacp_pkg::SECTOR_WORDS);
	assign wrTake = s_axi_awready;
	assign rdTake = s_axi_arready;
	assign wA = {s_axi_awaddr[7:2], 2'b00};
	assign rA = {s_axi_araddr[7:2], 2'b00};
	assign wMask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
		{8{s_axi_wstrb[0]}}};
	assign wd = s_axi_wdata & wMask;
	assign act = (wrTake && wA == atacp_pkg::OFS_ACTION) ? wd : 32'h0000_0000;
	// Late edges after the request drops or STOP rises are ignored
	assign rxTake = stbEdge && !dirIn && dmarq && !stopOn &&
		(bst == atacp_pkg::B_XFER || bst == atacp_pkg::B_TREQ);

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	always_comb
	begin
		next_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
		next_arready = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
		next_bvalid = wrTake || (s_axi_bvalid && !s_axi_bready);
		next_rvalid = rdTake || (s_axi_rvalid && !s_axi_rready);
		next_bresp = s_axi_bresp;
		next_rresp = s_axi_rresp;
		next_rdata = s_axi_rdata;
		next_cfg = cfg;
		next_errAddr = errAddr;
		rdHit = 1'b1;
		rdWord = 32'h0000_0000;
		if (rA == atacp_pkg::OFS_CONFIG)
			rdWord = cfg;
		else if (rA == atacp_pkg::OFS_STATUS)
			rdWord = {opcode, errReg, 3'h0, crcErr, intrq, err, drq, bsy, 1'b0, bst, 1'b0, cmdSt};
		else if (rA == atacp_pkg::OFS_ERRADDR)
			rdWord = {4'h0, errAddr};
		else if (rA == atacp_pkg::OFS_TXWORD)
			rdWord = {15'h0000, txValid, txWord};
		else if (rA == atacp_pkg::OFS_RXWORD)
			rdWord = {15'h0000, rxValid, rxWord};
		else if (rA == atacp_pkg::OFS_CRC)
			rdWord = {hostCrc, crc};
		else if (rA != atacp_pkg::OFS_ACTION)
			rdHit = 1'b0;
		if (rdTake)
		begin
			next_rdata = rdWord;
			next_rresp = rdHit ? atacp_pkg::RESP_OKAY : atacp_pkg::RESP_SLVERR;
		end
		if (wrTake)
		begin
			next_bresp = atacp_pkg::RESP_OKAY;
			if (wA == atacp_pkg::OFS_CONFIG)
				next_cfg = (cfg & ~wMask) | wd;
			else if (wA == atacp_pkg::OFS_ERRADDR)
				next_errAddr = 28'((errAddr & ~wMask[27:0]) | wd[27:0]);
			else if (wA != atacp_pkg::OFS_ACTION && wA != atacp_pkg::OFS_TXWORD)
				next_bresp = atacp_pkg::RESP_SLVERR;
		end
	end

	// ----------------------------------------------------------------
	// Command protocol and burst engine
	// ----------------------------------------------------------------
	always_comb
	begin
		next_cmdSt = cmdSt;
		next_bsy = bsy;
		next_drq = drq;
		next_err = err;
		next_errReg = errReg;
		next_opcode = opcode;
		next_wordCnt = wordCnt;
		next_crcErr = crcErr;
		next_errAddrLoad = 1'b0;
		next_intrq = intrq;
		setIntr = 1'b0;
		finish = 1'b0;
		if (statEdge || cmdEdge)
			next_intrq = 1'b0;
		case (cmdSt)
			atacp_pkg::C_IDLE:
				if (cmdEdge)
				begin
					// Parameters are already in place when the opcode lands
					next_opcode = ddS[7:0];
					next_bsy = 1'b1;
					next_drq = 1'b0;
					next_err = 1'b0;
					next_errReg = 8'h00;
					next_crcErr = 1'b0;
					next_cmdSt = atacp_pkg::C_BUSY;
				end
			atacp_pkg::C_BUSY:
				if (act[atacp_pkg::ACT_GRANT] && (cls == atacp_pkg::CLS_PIO ||
					cls == atacp_pkg::CLS_PIOMULT))
				begin
					next_drq = 1'b1;
					next_bsy = 1'b0;
					next_wordCnt = 16'h0000;
					next_cmdSt = atacp_pkg::C_DRQ;
				end
				else if (act[atacp_pkg::ACT_DMA] && cls == atacp_pkg::CLS_DMA && udmaEn)
					next_cmdSt = atacp_pkg::C_DMA;
			atacp_pkg::C_DRQ:
				if (dataEdge)
				begin
					next_wordCnt = 16'(wordCnt + 16'h0001);
					if (wordCnt == 16'(blockWords - 16'h0001))
					begin
						next_drq = 1'b0;
						next_bsy = 1'b1;
						next_cmdSt = atacp_pkg::C_PROC;
					end
				end
			atacp_pkg::C_PROC:
				if (act[atacp_pkg::ACT_PROC])
				begin
					next_drq = 1'b1;
					next_bsy = 1'b0;
					setIntr = 1'b1;
					next_wordCnt = 16'h0000;
					next_cmdSt = atacp_pkg::C_DRQ;
				end
			default:
				;
		endcase
		if (rxTake || (pend && gapCnt == 8'h00 && bst == atacp_pkg::B_XFER))
			next_wordCnt = 16'(wordCnt + 16'h0001);
		if (bst == atacp_pkg::B_TACK && !dmackOn && ddS != crc)
			next_crcErr = 1'b1;
		if (cmdSt != atacp_pkg::C_IDLE)
		begin
			if (act[atacp_pkg::ACT_ABORT])
			begin
				next_bsy = 1'b0;
				next_drq = 1'b0;
				next_err = 1'b1;
				next_errReg = 8'h00;
				next_errReg[atacp_pkg::ERR_ABRT_BIT] = 1'b1;
				setIntr = 1'b1;
				next_cmdSt = atacp_pkg::C_IDLE;
			end
			else if (act[atacp_pkg::ACT_FAULT])
			begin
				next_drq = 1'b1;
				next_bsy = 1'b0;
				next_err = 1'b1;
				next_errReg = act[atacp_pkg::ACT_CAUSE_LSB +: 8];
				next_errAddrLoad = 1'b1;
				setIntr = 1'b1;
				next_wordCnt = 16'h0000;
				next_cmdSt = atacp_pkg::C_DRQ;
			end
			else if (act[atacp_pkg::ACT_DONE])
				finish = 1'b1;
		end
		if (finish)
		begin
			// Only interrupt of a DMA command besides abort and fault; CRC errors surface here
			next_bsy = 1'b0;
			next_drq = 1'b0;
			next_err = err || crcErr;
			setIntr = 1'b1;
			next_cmdSt = atacp_pkg::C_IDLE;
		end
		if (setIntr)
			next_intrq = 1'b1;
		if (hostRst)
		begin
			next_bsy = 1'b0;
			next_drq = 1'b0;
			next_intrq = 1'b0;
			next_cmdSt = atacp_pkg::C_IDLE;
		end
	end

	always_comb
	begin
		next_bst = bst;
		next_dmarq = dmarq;
		next_dRdyStb = dRdyStb;
		next_ddOe = ddOe;
		next_ddOut = ddOut;
		next_crc = crc;
		next_hostCrc = hostCrc;
		next_burstCnt = burstCnt;
		next_gapCnt = (gapCnt != 8'h00) ? 8'(gapCnt - 8'h01) : gapCnt;
		next_pend = pend;
		next_txWord = txWord;
		next_txValid = txValid;
		next_rxWord = rxWord;
		next_rxValid = rxValid;
		if (rdTake && rA == atacp_pkg::OFS_RXWORD)
			next_rxValid = 1'b0;
		case (bst)
			atacp_pkg::B_IDLE:
				// Bursts start only on request, never on bare acknowledge
				if (act[atacp_pkg::ACT_DMA] && udmaEn && cls == atacp_pkg::CLS_DMA &&
					(cmdSt == atacp_pkg::C_BUSY || cmdSt == atacp_pkg::C_DMA))
				begin
					next_dmarq = 1'b1;
					next_dRdyStb = 1'b1;
					next_bst = atacp_pkg::B_REQ;
				end
			atacp_pkg::B_REQ:
				if (dmackOn && !stopOn)
				begin
					next_crc = atacp_pkg::CRC_SEED;
					next_burstCnt = 9'h000;
					next_pend = 1'b0;
					next_gapCnt = 8'h00;
					next_dRdyStb = dirIn;
					next_bst = atacp_pkg::B_XFER;
				end
			atacp_pkg::B_XFER:
				if (stopOn)
				begin
					next_dmarq = 1'b0;
					next_bst = atacp_pkg::B_TACK;
				end
				else if (dirIn)
				begin
					if (!ddOe && rdyOn)
						next_ddOe = 1'b1;
					if (ddOe && pend && gapCnt == 8'h00)
					begin
						next_dRdyStb = ~dRdyStb;
						next_crc = atacp_pkg::crcStep(crc, ddOut);
						next_burstCnt = 9'(burstCnt + 9'h001);
						next_pend = 1'b0;
						next_gapCnt = 8'(period - 8'h01);
					end
					// Host ready high withholds new words: a pause
					else if (ddOe && !pend && txValid && rdyOn)
					begin
						next_ddOut = txWord;
						next_txValid = 1'b0;
						next_pend = 1'b1;
					end
					else if (!pend && burstCnt == 9'(atacp_pkg::SECTOR_WORDS))
						next_bst = atacp_pkg::B_TREQ;
				end
				else if (burstCnt == 9'(atacp_pkg::SECTOR_WORDS))
				begin
					next_dRdyStb = 1'b1;
					next_bst = atacp_pkg::B_TREQ;
				end
			atacp_pkg::B_TREQ:
				if (dmarq)
					next_dmarq = 1'b0;
				else if (stopOn)
					next_bst = atacp_pkg::B_TACK;
			atacp_pkg::B_TACK:
			begin
				// Return edge carries no data and no CRC update
				next_dRdyStb = 1'b1;
				next_ddOe = 1'b0;
				next_pend = 1'b0;
				if (!dmackOn)
				begin
					next_hostCrc = ddS;
					next_bst = atacp_pkg::B_IDLE;
				end
			end
			default:
				next_bst = atacp_pkg::B_IDLE;
		endcase
		if (rxTake)
		begin
			next_rxWord = ddS;
			next_rxValid = 1'b1;
			next_crc = atacp_pkg::crcStep(crc, ddS);
			next_burstCnt = 9'(burstCnt + 9'h001);
		end
		if (wrTake && wA == atacp_pkg::OFS_TXWORD)
		begin
			next_txWord = wd[15:0];
			next_txValid = 1'b1;
		end
		if (hostRst)
		begin
			next_dmarq = 1'b0;
			next_ddOe = 1'b0;
			next_dRdyStb = 1'b1;
			next_pend = 1'b0;
			next_bst = atacp_pkg::B_IDLE;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= atacp_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= atacp_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			cfg <= atacp_pkg::CFG_RESET;
			errAddr <= 28'h000_0000;
			cmdSt <= atacp_pkg::C_IDLE;
			bst <= atacp_pkg::B_IDLE;
			bsy <= 1'b0;
			drq <= 1'b0;
			err <= 1'b0;
			errReg <= 8'h00;
			opcode <= 8'h00;
			intrq <= 1'b0;
			errAddrLoad <= 1'b0;
			wordCnt <= 16'h0000;
			crcErr <= 1'b0;
			dmarq <= 1'b0;
			dRdyStb <= 1'b1;
			ddOe <= 1'b0;
			ddOut <= 16'h0000;
			crc <= atacp_pkg::CRC_SEED;
			hostCrc <= 16'h0000;
			burstCnt <= 9'h000;
			gapCnt <= 8'h00;
			pend <= 1'b0;
			txWord <= 16'h0000;
			txValid <= 1'b0;
			rxWord <= 16'h0000;
			rxValid <= 1'b0;
		end
		else
		begin
			s_axi_awready <= next_awready;
			s_axi_wready <= next_awready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
			cfg <= next_cfg;
			errAddr <= next_errAddr;
			cmdSt <= next_cmdSt;
			bst <= next_bst;
			bsy <= next_bsy;
			drq <= next_drq;
			err <= next_err;
			errReg <= next_errReg;
			opcode <= next_opcode;
			intrq <= next_intrq;
			errAddrLoad <= next_errAddrLoad;
			wordCnt <= next_wordCnt;
			crcErr <= next_crcErr;
			dmarq <= next_dmarq;
			dRdyStb <= next_dRdyStb;
			ddOe <= next_ddOe;
			ddOut <= next_ddOut;
			crc <= next_crc;
			hostCrc <= next_hostCrc;
			burstCnt <= next_burstCnt;
			gapCnt <= next_gapCnt;
			pend <= next_pend;
			txWord <= next_txWord;
			txValid <= next_txValid;
			rxWord <= next_rxWord;
			rxValid <= next_rxValid;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_SECTOR_FULL: assert property (@(posedge clk) disable iff (sys_rst)
		(cmdSt == atacp_pkg::C_DRQ && dataEdge && !hostRst && act == 32'h0000_0000 &&
		wordCnt == 16'(blockWords - 16'h0001)) |=> (bsy && !drq))
		else $error("Full sector did not raise busy");
	AST_PROC_DONE: assert property (@(posedge clk) disable iff (sys_rst)
		(cmdSt == atacp_pkg::C_PROC && act[atacp_pkg::ACT_PROC] && !hostRst &&
		act[4:2] == 3'h0) |=> (drq && !bsy && intrq))
		else $error("Sector processing end not signalled");
	AST_INTR_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
		(statEdge && !setIntr) |=> !intrq)
		else $error("Status read left interrupt pending");
	AST_ABORT: assert property (@(posedge clk) disable iff (sys_rst)
		(act[atacp_pkg::ACT_ABORT] && cmdSt != atacp_pkg::C_IDLE && !hostRst) |=>
		(!bsy && err && errReg[atacp_pkg::ERR_ABRT_BIT] && intrq && cmdSt == atacp_pkg::C_IDLE))
		else $error("Abort did not end the command");
	AST_FAULT: assert property (@(posedge clk) disable iff (sys_rst)
		(act[atacp_pkg::ACT_FAULT] && !act[atacp_pkg::ACT_ABORT] && !hostRst &&
		cmdSt != atacp_pkg::C_IDLE) |=> (drq && err && errAddrLoad && intrq &&
		errReg == $past(act[atacp_pkg::ACT_CAUSE_LSB +: 8])))
		else $error("Write fault not reported");
	AST_NODATA: assert property (@(posedge clk) disable iff (sys_rst)
		(cls == atacp_pkg::CLS_NODATA && $rose(bsy)) |-> !drq [*2])
		else $error("Non-data command raised data request");
	AST_DMA_ONE_INT: assert property (@(posedge clk) disable iff (sys_rst)
		(cmdSt == atacp_pkg::C_DMA && !intrq && act[4:2] == 3'h0) |=> !intrq)
		else $error("Interrupt inside a DMA command");
	AST_DMARQ_CAUSE: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(dmarq) |-> ($past(act[atacp_pkg::ACT_DMA]) && udmaEn))
		else $error("DMA request without readiness");
	AST_DRIVE_DD: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(ddOe) |-> $past(dmackOn && rdyOn && !stopOn && dirIn))
		else $error("Data bus driven before host ready");
	AST_TERM_ACK: assert property (@(posedge clk) disable iff (sys_rst)
		(bst == atacp_pkg::B_XFER && stopOn && dmarq && !hostRst) |=>
		(!dmarq && bst == atacp_pkg::B_TACK))
		else $error("Host stop not acknowledged");
	AST_GAP: assert property (@(posedge clk) disable iff (sys_rst)
		(dirIn && bst == atacp_pkg::B_XFER && $changed(dRdyStb) && !hostRst) |=>
		!$changed(dRdyStb))
		else $error("Strobe edges too close");
endmodule
`default_nettype wire

// file: tb/atacp_host_model.sv
// Host-side model that answers Ultra DMA data-out and data-in bursts
`timescale 1ns/1ns
`default_nettype none
module atacp_host_model (
	input wire logic clk, // Core clock
	input wire logic dmarq, // Device DMA request
	input wire logic dRdyStb, // Device ready, low active
	input wire logic [15:0] hostWord, // Bus value outside bursts
	input wire logic dirIn, // High: data-in, ready held low
	output logic dmackN = 1'b1, // DMA acknowledge, low active
	output logic hStop = 1'b0, // Termination request
	output logic hRdyStb = 1'b0, // Host data strobe
	output logic [15:0] ddIn // Data bus to device
);
	logic [3:0] tick = 4'h0;
	logic [7:0] word = 8'h00;
	always @(posedge clk)
	begin
		tick <= tick + 4'h1;
		// Data moves half a strobe period away from the edge
		if (tick[2:0] == 3'h3)
			word <= word + 8'h01;
		if (dmarq && dmackN && !hStop && tick == 4'hF)
			dmackN <= 1'b0;
		else if (!dirIn && !dmackN && dmarq && !hStop && !dRdyStb && tick[2:0] == 3'h7)
			hRdyStb <= ~hRdyStb;
		else if (!dmackN && !dmarq && !hStop)
			hStop <= 1'b1;
		else if (hStop && tick == 4'hF)
			{dmackN, hStop} <= 2'b10;
	end
	assign ddIn = dmackN ? hostWord : {8'h00, word};
endmodule
`default_nettype wire

// file: tb/atacp_engine_tb_top.sv
// Self-checking bench for the ATA command protocol engine
`timescale 1ns/1ns
`default_nettype none
module atacp_engine_tb_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, errReg, opcode;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
	logic [3:0] s_axi_wstrb = 4'hF, hp = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hostIn = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	wire logic hReset = hp[3], hCmdWr = hp[2], hDataWr = hp[1], hStatRd = hp[0];
	logic [15:0] ddIn, ddOut;
	logic dmackN, hStop, hRdyStb, ddOe, dmarq, dRdyStb, intrq, bsy, drq, err, errAddrLoad;
	logic [27:0] errAddr;
	int failures = 0, tests_run = 0, cycles = 0;
	// Class, action word, expected {bsy, drq, err, intrq, abort bit}
	logic [22:0] rows [4] = '{{2'h1, 16'h0001, 5'b01000}, {2'h0, 16'h0004, 5'b00010},
		{2'h0, 16'h0008, 5'b00111}, {2'h1, 16'h5510, 5'b01111}};
	atacp_engine dut (.*);
	atacp_host_model host (.clk, .dmarq, .dRdyStb, .hostWord(16'h0030), .dirIn(hostIn), .dmackN, .hStop,
		.hRdyStb, .ddIn);
	always #2 clk = ~clk;
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		if (seen !== exp)
			failures++;
	endtask
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		if (wr)
			{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
		else
			{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				{s_axi_awvalid, s_axi_wvalid} <= 2'b00;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!(wr ? s_axi_bvalid : s_axi_rvalid));
		{s_axi_bready, s_axi_rready} <= 2'b00;
		q = s_axi_rdata;
		r = wr ? s_axi_bresp : s_axi_rresp;
	endtask
	// Pins pass two sync flops, so allow the edge to land
	task automatic pulse(input int i);
		hp[i] <= 1'b1;
		repeat (2) @(posedge clk);
		hp[i] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		axi(0, 8'h04, 0);
		chk(q, 32'h0020_0000);
		axi(0, 8'h40, 0);
		chk({30'h0, r}, 32'h2);
		foreach (rows[k])
		begin
			pulse(3);
			pulse(2);
			chk({31'h0, bsy}, 32'h1);
			chk({24'h0, opcode}, 32'h30);
			axi(1, 8'h04, {14'h0, rows[k][22:21], 16'h0});
			axi(1, 8'h00, {16'h0, rows[k][20:5]});
			repeat (3) @(posedge clk);
			chk({bsy, drq, err, intrq, errReg[2]}, {27'h0, rows[k][4:0]});
			pulse(0);
			chk({31'h0, intrq}, 32'h0);
		end
		pulse(3);
		axi(1, 8'h04, 32'h0001_0000);
		pulse(2);
		axi(1, 8'h00, 32'h1);
		repeat (256) pulse(1);
		chk({bsy, drq}, 2'b10);
		axi(1, 8'h00, 32'h2);
		repeat (3) @(posedge clk);
		chk({bsy, drq, intrq}, 3'b011);
		pulse(3);
		axi(1, 8'h04, 32'h0003_000B);
		pulse(2);
		axi(1, 8'h00, 32'h20);
		wait (!dmackN);
		wait (dmackN);
		chk({intrq, ddOe, dmarq}, 3'b000);
		axi(1, 8'h00, 32'h4);
		repeat (3) @(posedge clk);
		chk({31'h0, intrq}, 32'h1);
		axi(0, 8'h18, 0);
		chk({16'h0, q[31:16]}, 32'h30);
		// Data-in burst: feed one word at a time, never overwrite a pending one
		pulse(3);
		hostIn <= 1'b1;
		axi(1, 8'h04, 32'h0007_000B);
		pulse(2);
		axi(1, 8'h00, 32'h20);
		repeat (256)
		begin
			do
				axi(0, 8'h10, 0);
			while (q[16]);
			axi(1, 8'h10, 32'hA5C3);
		end
		wait (dmackN);
		chk({ddOe, dmarq, dRdyStb}, 3'b001);
		axi(0, 8'h18, 0);
		chk({16'h0, q[31:16]}, 32'h30);
		final_report();
	end
endmodule
`default_nettype wire
